// >>> src/sdx_pkg.sv
// shared constants and types for the converter control and its serial master
package sdx_pkg;
   // serial word layout
   localparam int WORD_W = 16;
   localparam int MAG_W = 14;
   localparam int BIT_W = 5;
   localparam int LOAD_BIT = 15;
   localparam int SIGN_BIT = 15;
   localparam int OVR_BIT = 14;
   localparam int SPLIT_AT = 8;
   // clock ratio field inside the control word
   localparam int DIV_LSB = 7;
   localparam logic [1:0] DIV_BY1 = 2'h0;
   localparam logic [1:0] DIV_BY2 = 2'h1;
   localparam logic [1:0] DIV_BY4 = 2'h2;
   localparam logic [1:0] DIV_LAST2 = 2'h1;
   localparam logic [1:0] DIV_LAST4 = 2'h3;
   // power-up contents of shift and control registers
   localparam logic [WORD_W-1:0] RESET_WORD = 16'h0000;
   // timing: system clock and fastest serial clock
   localparam int MCLK_HZ = 100_000_000;
   localparam int SCLK_MAX_HZ = 2_000_000;
   // least half period rounds up to whole cycles
   localparam int SCLK_HALF_CYC = (MCLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
   localparam int BYTE_GAP_CYC = 64;
   localparam int CS_GUARD_CYC = 4;
   localparam int RC_HALF_CYC = 50;
   localparam int CONV_TICKS = 16384;
   localparam int TMR_W = 16;
   typedef logic [WORD_W-1:0] sdx_word_t;
endpackage : sdx_pkg

// >>> src/sdx_link_if.sv
// serial link between the converter and its master
`timescale 1ns/1ps
interface sdx_link_if;
   logic cs_n;    // select, active low
   logic sclk;    // serial clock, idles low
   logic mosi;    // data into the converter
   logic miso;    // data out of the converter
   logic miso_oe; // converter drives miso while high
   logic busy_n;  // low while a conversion runs

   // converter end
   modport dev
   (
      input cs_n,
      input sclk,
      input mosi,
      output miso,
      output miso_oe,
      output busy_n
   );

   // master end
   modport host
   (
      output cs_n,
      output sclk,
      output mosi,
      input miso,
      input miso_oe,
      input busy_n
   );
endinterface : sdx_link_if

// >>> src/sdx_dev.sv
// converter digital control: clock source, divider, counter, static shift register
// Operation
// - sign, overrange, then 14 magnitude bits MSB-first
// - two's complement; negative when inverting input higher
// - overrange flag when magnitude exceeded reference
// - oversampling clock divides source by 1, 2, 4
// - select low: oscillator off, clock pin input
// - select high: oscillator runs, drives clock pin
// - count comparator up/down, load result at end
// - static shift register, serial clock up to 2MHz
// - output bit changes on serial clock fall
// - master samples output on serial clock rise
// - input bit captured on serial clock rise
// - select rising starts conversion if load bit set
// - master keeps select high while busy low
// - select low mid-conversion stops it
// - master uses clock idle low, phase zero
// - without busy, master waits conversion time
// - master may poll busy for ready data
// - two byte bursts, pause unlimited, state kept
// - select stays low across both bytes
// - load bit set copies 15 control bits
// - serial output released while select high
// - previous result shifts out with next control
// - busy low at start, high at end
`timescale 1ns/1ps
module sdx_dev
#(
   parameter int CONV_LEN = sdx_pkg::CONV_TICKS,
   parameter int RC_HALF = sdx_pkg::RC_HALF_CYC,
   parameter int CNT_W = 18
)
(
   input wire logic mclk,
   input wire logic rst_n,
   sdx_link_if.dev link,
   input wire logic osc_source_select,
   input wire logic comp_i,
   input wire logic clk_pin_i,
   output logic clk_pin_o,
   output logic clk_pin_oe,
   output logic [sdx_pkg::WORD_W-2:0] ctrl_o,
   output logic conv_done_o
);
   import sdx_pkg::*;

   typedef enum logic [0:0] {SDX_IDLE, SDX_CONV} sdx_dev_st_e;

   localparam logic signed [CNT_W-1:0] MAG_MAX = CNT_W'((1 << MAG_W) - 1);
   localparam logic signed [CNT_W-1:0] MAG_MIN = -CNT_W'(1 << MAG_W);
   localparam logic [MAG_W-1:0] SAT_POS = {MAG_W{1'b1}};
   localparam logic [MAG_W-1:0] SAT_NEG = {MAG_W{1'b0}};
   localparam logic [TMR_W-1:0] RC_LAST = TMR_W'(RC_HALF - 1);
   localparam logic [CNT_W-1:0] TICK_LAST = CNT_W'(CONV_LEN - 1);

   // clock source group
   logic [TMR_W-1:0] rc_cnt_ff;   // internal oscillator half period timer
   logic [TMR_W-1:0] nxt_rc_cnt;
   logic rc_ff;                   // internal oscillator level
   logic nxt_rc;
   logic src_prev_ff;             // last level of the selected source
   logic nxt_src_prev;
   logic [1:0] div_cnt_ff;        // divider phase
   logic [1:0] nxt_div_cnt;
   logic src_lvl;                 // selected source level
   logic src_rise;                // selected source rising
   logic tick;                    // one oversampling clock

   // serial and conversion group
   sdx_dev_st_e st_ff;
   sdx_dev_st_e nxt_st;
   logic sclk_prev_ff;            // serial clock last cycle
   logic nxt_sclk_prev;
   logic cs_prev_ff;              // select last cycle
   logic nxt_cs_prev;
   logic din_ff;                  // bit taken at the last rise
   logic nxt_din;
   sdx_word_t shreg_ff;           // static i/o shift register
   sdx_word_t nxt_shreg;
   logic [WORD_W-2:0] ctrl_ff;    // control register
   logic [WORD_W-2:0] nxt_ctrl;
   logic signed [CNT_W-1:0] acc_ff; // up/down counter
   logic signed [CNT_W-1:0] nxt_acc;
   logic [CNT_W-1:0] ticks_ff;    // oversampling clocks so far
   logic [CNT_W-1:0] nxt_ticks;
   logic ovr_ff;                  // sticky overrange
   logic nxt_ovr;
   logic done_ff;                 // conversion finished pulse
   logic nxt_done;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_rise;

   // pack a count into the output word, saturating when over range
   function automatic sdx_word_t pack_result(input logic signed [CNT_W-1:0] c,
                                             input logic o);
      logic neg;
      logic [MAG_W-1:0] mag;
      neg = c[CNT_W-1];
      mag = c[MAG_W-1:0];
      if (o)
      begin
         mag = neg ? SAT_NEG : SAT_POS;
      end
      return {neg, o, mag};
   endfunction : pack_result

   // source select and divider ratio decode
   always_comb
   begin
      nxt_rc_cnt = rc_cnt_ff;
      nxt_rc = rc_ff;
      if (!osc_source_select)
      begin
         nxt_rc_cnt = '0;
         nxt_rc = 1'b0;
      end
      else if (rc_cnt_ff == RC_LAST)
      begin
         nxt_rc_cnt = '0;
         nxt_rc = !rc_ff;
      end
      else
      begin
         nxt_rc_cnt = rc_cnt_ff + TMR_W'(1);
      end
      // pin input is synchronous to mclk, so no extra stages
      src_lvl = osc_source_select ? rc_ff : clk_pin_i;
      src_rise = src_lvl && !src_prev_ff;
      nxt_src_prev = src_lvl;
      nxt_div_cnt = src_rise ? div_cnt_ff + 2'h1 : div_cnt_ff;
      // divide by one, two or four
      case (ctrl_ff[DIV_LSB+1:DIV_LSB])
         DIV_BY1: tick = src_rise;
         DIV_BY2: tick = src_rise && (div_cnt_ff[0] == DIV_LAST2[0]);
         DIV_BY4: tick = src_rise && (div_cnt_ff == DIV_LAST4);
         default: tick = src_rise;  // unused code behaves as divide by one
      endcase
   end

   // clock source registers
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rc_cnt_ff <= '0;
         rc_ff <= 1'b0;
         src_prev_ff <= 1'b0;
         div_cnt_ff <= 2'h0;
      end
      else
      begin
         rc_cnt_ff <= nxt_rc_cnt;
         rc_ff <= nxt_rc;
         src_prev_ff <= nxt_src_prev;
         div_cnt_ff <= nxt_div_cnt;
      end
   end

   assign clk_pin_o = rc_ff;
   assign clk_pin_oe = osc_source_select;

   // serial shifting and conversion sequencing
   always_comb
   begin
      nxt_st = st_ff;
      nxt_din = din_ff;
      nxt_shreg = shreg_ff;
      nxt_ctrl = ctrl_ff;
      nxt_acc = acc_ff;
      nxt_ticks = ticks_ff;
      nxt_ovr = ovr_ff;
      nxt_done = 1'b0;
      nxt_sclk_prev = link.sclk;
      nxt_cs_prev = link.cs_n;
      // edges only count while selected; level state keeps any pause
      sclk_rise = !link.cs_n && link.sclk && !sclk_prev_ff;
      sclk_fall = !link.cs_n && !link.sclk && sclk_prev_ff;
      cs_rise = link.cs_n && !cs_prev_ff;
      if (sclk_rise)
      begin
         nxt_din = link.mosi;
      end
      if (sclk_fall)
      begin
         nxt_shreg = {shreg_ff[WORD_W-2:0], din_ff};
      end
      case (st_ff)
         SDX_IDLE:
         begin
            if (cs_rise && shreg_ff[LOAD_BIT])
            begin
               nxt_ctrl = shreg_ff[WORD_W-2:0];
               nxt_acc = '0;
               nxt_ticks = '0;
               nxt_ovr = 1'b0;
               nxt_st = SDX_CONV;
            end
         end
         SDX_CONV:
         begin
            if (!link.cs_n)
            begin
               nxt_st = SDX_IDLE;
            end
            else if (tick)
            begin
               nxt_acc = comp_i ? acc_ff + CNT_W'(1) : acc_ff - CNT_W'(1);
               nxt_ticks = ticks_ff + CNT_W'(1);
               if (nxt_acc > MAG_MAX || nxt_acc < MAG_MIN)
               begin
                  nxt_ovr = 1'b1;
               end
               if (ticks_ff == TICK_LAST)
               begin
                  nxt_shreg = pack_result(nxt_acc, nxt_ovr);
                  nxt_done = 1'b1;
                  nxt_st = SDX_IDLE;
               end
            end
         end
         default: nxt_st = SDX_IDLE;
      endcase
   end

   // serial and conversion registers
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_ff <= SDX_IDLE;
         sclk_prev_ff <= 1'b0;
         cs_prev_ff <= 1'b1;
         din_ff <= 1'b0;
         shreg_ff <= RESET_WORD;
         ctrl_ff <= RESET_WORD[WORD_W-2:0];
         acc_ff <= '0;
         ticks_ff <= '0;
         ovr_ff <= 1'b0;
         done_ff <= 1'b0;
      end
      else
      begin
         st_ff <= nxt_st;
         sclk_prev_ff <= nxt_sclk_prev;
         cs_prev_ff <= nxt_cs_prev;
         din_ff <= nxt_din;
         shreg_ff <= nxt_shreg;
         ctrl_ff <= nxt_ctrl;
         acc_ff <= nxt_acc;
         ticks_ff <= nxt_ticks;
         ovr_ff <= nxt_ovr;
         done_ff <= nxt_done;
      end
   end

   assign link.miso = shreg_ff[WORD_W-1];
   assign link.miso_oe = !link.cs_n;
   assign link.busy_n = (st_ff != SDX_CONV);
   assign ctrl_o = ctrl_ff;
   assign conv_done_o = done_ff;
endmodule : sdx_dev

// >>> src/sdx_host.sv
// serial master: writes a control word, reads the result into a two-entry buffer
`timescale 1ns/1ps
module sdx_host
#(
   parameter int HALF = sdx_pkg::SCLK_HALF_CYC,
   parameter int GAP = sdx_pkg::BYTE_GAP_CYC,
   parameter int GUARD = sdx_pkg::CS_GUARD_CYC
)
(
   input wire logic mclk,
   input wire logic rst_n,
   sdx_link_if.host link,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input sdx_pkg::sdx_word_t cmd_word,
   input wire logic split_i,
   output logic rsp_valid,
   input wire logic rsp_ready,
   output sdx_pkg::sdx_word_t rsp_word
);
   import sdx_pkg::*;

   typedef enum logic [2:0] {SDX_H_IDLE, SDX_H_LOW, SDX_H_HIGH, SDX_H_GAP, SDX_H_END,
                             SDX_H_GUARD} sdx_host_st_e;

   localparam logic [TMR_W-1:0] HALF_LAST = TMR_W'(HALF - 1);
   localparam logic [TMR_W-1:0] GAP_LAST = TMR_W'(GAP - 1);
   localparam logic [TMR_W-1:0] GUARD_LAST = TMR_W'(GUARD - 1);
   localparam logic [BIT_W-1:0] BITS_ALL = BIT_W'(WORD_W);
   localparam logic [BIT_W-1:0] BITS_HALF = BIT_W'(SPLIT_AT);
   localparam logic [1:0] FIFO_FULL = 2'h2;

   sdx_host_st_e st_ff;
   sdx_host_st_e nxt_st;
   logic [TMR_W-1:0] tmr_ff;       // phase timer
   logic [TMR_W-1:0] nxt_tmr;
   logic [BIT_W-1:0] bit_ff;       // completed clock pulses
   logic [BIT_W-1:0] nxt_bit;
   logic cs_n_ff;
   logic nxt_cs_n;
   logic sclk_ff;
   logic nxt_sclk;
   logic mosi_ff;
   logic nxt_mosi;
   logic split_ff;                 // burst split latched per word
   logic nxt_split;
   sdx_word_t tx_ff;               // outgoing control word
   sdx_word_t nxt_tx;
   sdx_word_t rx_ff;               // incoming result
   sdx_word_t nxt_rx;
   sdx_word_t mem_ff [2];          // result buffer
   sdx_word_t nxt_mem [2];
   logic wr_ff;
   logic nxt_wr;
   logic rd_ff;
   logic nxt_rd;
   logic [1:0] cnt_ff;             // words held
   logic [1:0] nxt_cnt;
   logic push;
   logic pop;
   logic [BIT_W-1:0] bit_inc;

   // start only on ready data; a full buffer stalls the next word
   assign cmd_ready = (st_ff == SDX_H_IDLE) && link.busy_n && (cnt_ff != FIFO_FULL);

   // transfer sequencer and buffer
   always_comb
   begin
      nxt_st = st_ff;
      nxt_tmr = tmr_ff + TMR_W'(1);
      nxt_bit = bit_ff;
      nxt_cs_n = cs_n_ff;
      nxt_sclk = sclk_ff;
      nxt_mosi = mosi_ff;
      nxt_split = split_ff;
      nxt_tx = tx_ff;
      nxt_rx = rx_ff;
      push = 1'b0;
      bit_inc = bit_ff + BIT_W'(1);
      case (st_ff)
         SDX_H_IDLE:
         begin
            nxt_tmr = '0;
            // clock idles low, first bit set up before first rise
            if (cmd_valid && cmd_ready)
            begin
               nxt_tx = cmd_word;
               nxt_mosi = cmd_word[WORD_W-1];
               nxt_cs_n = 1'b0;
               nxt_bit = '0;
               nxt_split = split_i;
               nxt_st = SDX_H_LOW;
            end
         end
         SDX_H_LOW:
         begin
            // half period keeps clock within its limit
            if (tmr_ff == HALF_LAST)
            begin
               nxt_tmr = '0;
               nxt_sclk = 1'b1;
               nxt_rx = {rx_ff[WORD_W-2:0], link.miso};
               nxt_st = SDX_H_HIGH;
            end
         end
         SDX_H_HIGH:
         begin
            if (tmr_ff == HALF_LAST)
            begin
               nxt_tmr = '0;
               nxt_sclk = 1'b0;
               nxt_bit = bit_inc;
               nxt_tx = {tx_ff[WORD_W-2:0], 1'b0};
               nxt_mosi = tx_ff[WORD_W-2];
               if (bit_inc == BITS_ALL)
               begin
                  nxt_st = SDX_H_END;
               end
               else if (split_ff && bit_inc == BITS_HALF)
               begin
                  nxt_st = SDX_H_GAP;
               end
               else
               begin
                  nxt_st = SDX_H_LOW;
               end
            end
         end
         SDX_H_GAP:
         begin
            if (tmr_ff == GAP_LAST)
            begin
               nxt_tmr = '0;
               nxt_st = SDX_H_LOW;
            end
         end
         SDX_H_END:
         begin
            if (tmr_ff == HALF_LAST)
            begin
               nxt_tmr = '0;
               nxt_cs_n = 1'b1;
               push = 1'b1;
               nxt_st = SDX_H_GUARD;
            end
         end
         SDX_H_GUARD:
         begin
            // give busy time to fall before polling it again
            if (tmr_ff == GUARD_LAST)
            begin
               nxt_tmr = '0;
               nxt_st = SDX_H_IDLE;
            end
         end
         default: nxt_st = SDX_H_IDLE;
      endcase
      // two-entry buffer; push never meets a full buffer by cmd_ready
      pop = rsp_valid && rsp_ready;
      nxt_mem = mem_ff;
      nxt_wr = wr_ff;
      nxt_rd = rd_ff;
      if (push)
      begin
         nxt_mem[wr_ff] = rx_ff;
         nxt_wr = !wr_ff;
      end
      if (pop)
      begin
         nxt_rd = !rd_ff;
      end
      nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};
   end

   // sequencer and buffer registers
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_ff <= SDX_H_IDLE;
         tmr_ff <= '0;
         bit_ff <= '0;
         cs_n_ff <= 1'b1;
         sclk_ff <= 1'b0;
         mosi_ff <= 1'b0;
         split_ff <= 1'b0;
         tx_ff <= RESET_WORD;
         rx_ff <= RESET_WORD;
         mem_ff[0] <= RESET_WORD;
         mem_ff[1] <= RESET_WORD;
         wr_ff <= 1'b0;
         rd_ff <= 1'b0;
         cnt_ff <= 2'h0;
      end
      else
      begin
         st_ff <= nxt_st;
         tmr_ff <= nxt_tmr;
         bit_ff <= nxt_bit;
         cs_n_ff <= nxt_cs_n;
         sclk_ff <= nxt_sclk;
         mosi_ff <= nxt_mosi;
         split_ff <= nxt_split;
         tx_ff <= nxt_tx;
         rx_ff <= nxt_rx;
         mem_ff <= nxt_mem;
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
         cnt_ff <= nxt_cnt;
      end
   end

   assign link.cs_n = cs_n_ff;
   assign link.sclk = sclk_ff;
   assign link.mosi = mosi_ff;
   assign rsp_valid = (cnt_ff != 2'h0);
   assign rsp_word = mem_ff[rd_ff];
endmodule : sdx_host

// >>> verif/sdx_link_props.sv
// concurrent checks on the serial link between converter and master
`timescale 1ns/1ps
module sdx_link_props
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe,
   input wire logic busy_n
);
   // longest conversion the bench asks of the main pair, with slack
   localparam int BUSY_MAX = 900;
   logic sclk_q_ff; // sclk one cycle back
   logic [15:0] rx_ff; // mosi bits taken at rises
   logic [4:0] rises_ff; // rises seen while selected
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // find rises the same way the converter does, so counts agree
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sclk_q_ff <= 1'b0;
         rx_ff <= 16'h0000;
         rises_ff <= 5'h00;
      end
      else
      begin
         sclk_q_ff <= sclk;
         if (cs_n)
            rises_ff <= 5'h00;
         else if (sclk && !sclk_q_ff)
         begin
            rises_ff <= rises_ff + 5'h01;
            rx_ff <= {rx_ff[14:0], mosi};
         end
      end
   end
   chk_oe_follows_select: assert property (miso_oe == !cs_n)
      else $error("miso enable does not follow select");
   chk_miso_on_fall: assert property (!cs_n && !$past(cs_n) && !$past(cs_n, 2) && $changed(miso)
      |-> !$past(sclk) && $past(sclk, 2))
      else $error("miso changed without a serial clock fall");
   chk_sclk_idle_low: assert property (cs_n |-> !sclk)
      else $error("serial clock high while deselected");
   chk_mosi_steady_high: assert property (!cs_n && sclk |-> $stable(mosi))
      else $error("mosi moved while serial clock high");
   chk_sixteen_rises: assert property ($rose(cs_n) |-> rises_ff == 5'h10)
      else $error("frame closed without sixteen clock rises");
   chk_load_starts: assert property ($rose(cs_n) && rx_ff[15] |=> !busy_n)
      else $error("load bit set but no conversion started");
   chk_noload_idle: assert property ($rose(cs_n) && !rx_ff[15] |=> busy_n [*4])
      else $error("conversion started without load bit");
   chk_busy_start: assert property ($fell(busy_n) |-> $past(cs_n) && !$past(cs_n, 2))
      else $error("busy fell without a select rise");
   chk_busy_ends: assert property ($fell(busy_n) |-> ##[1:BUSY_MAX] busy_n)
      else $error("conversion did not finish in time");
   chk_select_held: assert property (!busy_n |-> cs_n)
      else $error("select low during conversion");
   cov_conversion: cover property ($fell(busy_n) ##[1:BUSY_MAX] $rose(busy_n));
   cov_frame: cover property ($rose(cs_n) && rises_ff == 5'h10);
   cov_noload: cover property ($rose(cs_n) && !rx_ff[15]);
endmodule : sdx_link_props

// >>> verif/tb_sigma_delta_adc_serial_ctrl.sv
// self-checking bench: converter and master joined, plus a bench-driven converter
`timescale 1ns/1ps
module tb_sigma_delta_adc_serial_ctrl;
   import sdx_pkg::*;
   localparam int CONV1 = 32; // short conversion for the joined pair
   localparam int CONV2 = 16400; // long enough to pass full scale
   localparam int RCH = 2; // oscillator half period in mclk cycles
   logic mclk, rst_n, osc_sel, comp, comp2, clk2, osc_v, done2_seen, sclk_q;
   logic cmd_valid, cmd_ready, split, rsp_valid, rsp_ready, clk_o, clk_oe, clk_oe2;
   logic done, done2;
   logic [WORD_W-2:0] ctrl, ctrl2;
   logic [1:0] dcode [3] = '{DIV_BY1, DIV_BY2, DIV_BY4}; // ratio codes in order
   sdx_word_t cmd_word, rsp_word, mon_mosi, mon_miso, rd, w;
   int n_errors = 0;
   int total_checks = 0;
   sdx_link_if link();
   sdx_link_if link2(); // second converter, driven by the bench itself
   sdx_dev #(.CONV_LEN(CONV1), .RC_HALF(RCH)) i_sdx_dev
   (
      .mclk(mclk), .rst_n(rst_n), .link(link.dev), .osc_source_select(osc_sel),
      .comp_i(comp), .clk_pin_i(clk2), .clk_pin_o(clk_o), .clk_pin_oe(clk_oe),
      .ctrl_o(ctrl), .conv_done_o(done)
   );
   sdx_dev #(.CONV_LEN(CONV2), .RC_HALF(RCH)) i_sdx_dev_b
   (
      .mclk(mclk), .rst_n(rst_n), .link(link2.dev), .osc_source_select(1'b0),
      .comp_i(comp2), .clk_pin_i(clk2), .clk_pin_o(), .clk_pin_oe(clk_oe2),
      .ctrl_o(ctrl2), .conv_done_o(done2)
   );
   sdx_host i_sdx_host
   (
      .mclk(mclk), .rst_n(rst_n), .link(link.host), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_word(cmd_word), .split_i(split),
      .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_word(rsp_word)
   );
   sdx_link_props i_sdx_link_props
   (
      .mclk(mclk), .rst_n(rst_n), .cs_n(link.cs_n), .sclk(link.sclk), .mosi(link.mosi),
      .miso(link.miso), .miso_oe(link.miso_oe), .busy_n(link.busy_n)
   );
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // external conversion clock, one rise every two mclk cycles
   always @(posedge mclk)
      clk2 <= ~clk2;
   // wire monitor: both data lines taken at serial clock rises
   always @(posedge mclk)
   begin
      sclk_q <= link.sclk;
      if (link.sclk && !sclk_q && !link.cs_n)
      begin
         mon_mosi <= {mon_mosi[14:0], link.mosi};
         mon_miso <= {mon_miso[14:0], link.miso};
      end
      if (done2)
         done2_seen <= 1'b1;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic conclude();
      if (n_errors == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   // offer one command and hold it until the master takes it
   task automatic cmd(input sdx_word_t cw, input logic sp);
      @(posedge mclk);
      cmd_valid <= 1'b1;
      cmd_word <= cw;
      split <= sp;
      @(negedge mclk);
      for (int i = 0; i < 20000 && cmd_ready !== 1'b1; i++)
         @(negedge mclk);
      chk(cmd_ready, 1'b1);
      @(posedge mclk);
      cmd_valid <= 1'b0;
   endtask : cmd
   // take one response word and compare it
   task automatic pop(input sdx_word_t exp);
      @(negedge mclk);
      for (int i = 0; i < 20000 && rsp_valid !== 1'b1; i++)
         @(negedge mclk);
      chk(rsp_word, exp);
      @(posedge mclk);
      rsp_ready <= 1'b1;
      @(posedge mclk);
      rsp_ready <= 1'b0;
   endtask : pop
   // busy low time must scale with the ratio; tolerance is two oversampling clocks
   task automatic conv_time(input int div);
      int n = 0;
      int exp = CONV1 * div * 2 * RCH;
      while (link.busy_n !== 1'b1 && n < 5000)
      begin
         @(posedge mclk);
         n++;
      end
      // done pulse stands for the cycle in which busy returns high
      chk(done, 1'b1);
      chk(n >= exp - 4 * RCH * div - 8 && n <= exp + 4 * RCH * div, 1'b1);
   endtask : conv_time
   // bench as master of the second converter; pause mid-word keeps select low
   task automatic xfer2(input sdx_word_t cw);
      @(posedge mclk);
      link2.cs_n <= 1'b0;
      link2.mosi <= cw[15];
      for (int i = 15; i >= 0; i--)
      begin
         repeat (3) @(posedge mclk);
         link2.sclk <= 1'b1;
         rd <= {rd[14:0], link2.miso};
         repeat (3) @(posedge mclk);
         link2.sclk <= 1'b0;
         link2.mosi <= cw[(i + 15) % 16];
         if (i == 8)
            repeat (200) @(posedge mclk);
      end
      repeat (3) @(posedge mclk);
      link2.cs_n <= 1'b1;
   endtask : xfer2
   initial
   begin
      repeat (90000) @(posedge mclk);
      n_errors++;
      conclude();
   end
   initial
   begin
      rst_n = 1'b0;
      osc_sel = 1'b1;
      comp = 1'b1;
      comp2 = 1'b1;
      clk2 = 1'b0;
      cmd_valid = 1'b0;
      cmd_word = 16'h0000;
      split = 1'b0;
      rsp_ready = 1'b0;
      rd = 16'h0000;
      done2_seen = 1'b0;
      link2.cs_n = 1'b1;
      link2.sclk = 1'b0;
      link2.mosi = 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      @(negedge mclk);
      chk(ctrl, 16'h0000);
      chk(clk_oe, 1'b1);
      chk(clk_oe2, 1'b0);
      chk(link2.miso_oe, 1'b0);
      osc_v = clk_o;
      repeat (RCH) @(negedge mclk);
      chk(clk_o, !osc_v);
      // positive input at each ratio; each read returns the previous result
      for (int k = 0; k < 3; k++)
      begin
         w = 16'h8000 | (16'(dcode[k]) << DIV_LSB);
         cmd(w, 1'b0);
         pop(k == 0 ? RESET_WORD : 16'h0020);
         chk(mon_miso, k == 0 ? RESET_WORD : 16'h0020);
         chk(mon_mosi, w);
         chk(ctrl, w[14:0]);
         conv_time(1 << k);
      end
      comp <= 1'b0;
      w = 16'h8000 | (16'(DIV_BY2) << DIV_LSB);
      cmd(w, 1'b1);
      pop(16'h0020);
      chk(mon_mosi, w);
      conv_time(2);
      // no-load words while the response side stalls
      cmd(16'h7FFF, 1'b0);
      cmd(16'h7FFF, 1'b0);
      // let the second frame and its guard finish, so only the full buffer refuses
      repeat (WORD_W * 2 * SCLK_HALF_CYC + SCLK_HALF_CYC + CS_GUARD_CYC + 20) @(negedge mclk);
      chk(cmd_ready, 1'b0); // buffer full refuses
      chk(link.busy_n, 1'b1);
      chk(ctrl, w[14:0]);
      pop(16'hBFE0);
      pop(16'h7FFF);
      @(negedge mclk);
      chk(rsp_valid, 1'b0); // buffer drained
      // full scale on the second converter, external clock
      xfer2(16'h8000);
      repeat (4) @(posedge mclk);
      for (int i = 0; i < 40000 && link2.busy_n !== 1'b1; i++)
         @(posedge mclk);
      xfer2(16'h8000);
      chk(rd, 16'h7FFF);
      repeat (50) @(posedge mclk);
      chk(link2.busy_n, 1'b0);
      done2_seen = 1'b0;
      // select dropped mid-conversion
      // no-load word with all other bits set must leave control untouched
      xfer2(16'h7FFF);
      repeat (10) @(posedge mclk);
      chk(link2.busy_n, 1'b1);
      chk(done2_seen, 1'b0);
      chk(ctrl2, 16'h0000);
      conclude();
   end
endmodule : tb_sigma_delta_adc_serial_ctrl
